// File: core/ccrcm_pkg.sv
// package for the configuration memory crc monitor
package ccrcm_pkg;
  localparam int          CCRCM_ADDR_W     = 8;
  localparam int          CCRCM_DATA_W     = 32;
  localparam int          CCRCM_CRC_W      = 32;
  localparam int          CCRCM_WORDS      = 16;
  localparam int          CCRCM_IDX_W      = 4;
  localparam logic [31:0] CCRCM_CRC_POLY   = 32'h04c1_1db7;
  localparam logic [31:0] CCRCM_CRC_SEED   = 32'hffff_ffff;
  localparam logic [3:0]  CCRCM_IDX_LAST   = 4'hf;
  localparam int          CCRCM_CLK_MHZ    = 250;
  localparam int          CCRCM_RATE_STEPS = 16;
  localparam logic [3:0]  CCRCM_RATE_DFLT  = 4'h0;
  // register offsets (byte addresses)
  localparam logic [7:0] CCRCM_OFS_CTRL   = 8'h00;
  localparam logic [7:0] CCRCM_OFS_STAT   = 8'h04;
  localparam logic [7:0] CCRCM_OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] CCRCM_OFS_IRQ_MK = 8'h0c;
  localparam logic [7:0] CCRCM_OFS_REF    = 8'h10;
  localparam logic [7:0] CCRCM_OFS_LAST   = 8'h14;
  // control field positions
  localparam int CCRCM_CTRL_EN   = 0;
  localparam int CCRCM_CTRL_HALT = 1;
  localparam int CCRCM_CTRL_RATE = 4;
  // interrupt bits: mismatch, pass done
  localparam int CCRCM_IRQ_W     = 2;
  localparam int CCRCM_IRQ_MIS   = 0;
  localparam int CCRCM_IRQ_DONE  = 1;
  typedef enum logic [1:0] {
    CCRCM_IDLE  = 2'b00,
    CCRCM_WAIT  = 2'b01,
    CCRCM_READ  = 2'b10,
    CCRCM_STOP  = 2'b11
  } ccrcm_state_t;
endpackage : ccrcm_pkg

// File: core/ccrcm_top.sv
// configuration memory crc monitor top level
`timescale 1ns/100ps
`default_nettype none
module ccrcm_top
  import ccrcm_pkg::*;
(
  // clock and reset
  input  wire logic                              ref_clk_i,
  input  wire logic                              reset_i,
  // configuration state
  input  wire logic                              config_start_i,
  input  wire logic                              config_done_i,
  input  wire logic                              cfg_status_drive_low_i,
  // configuration memory readback
  output logic [ccrcm_pkg::CCRCM_IDX_W-1:0]      rb_index_o,
  input  wire logic [ccrcm_pkg::CCRCM_DATA_W-1:0] rb_data_i,
  // status pin, open drain
  input  wire logic                              status_pin_i,
  output logic                                   status_pin_o,
  output logic                                   status_pin_oe_o,
  // register port
  input  wire logic [ccrcm_pkg::CCRCM_ADDR_W-1:0] reg_addr_i,
  input  wire logic [ccrcm_pkg::CCRCM_DATA_W-1:0] reg_wdata_i,
  input  wire logic                              reg_wr_i,
  input  wire logic                              reg_rd_i,
  output logic [ccrcm_pkg::CCRCM_DATA_W-1:0]     reg_rdata_o,
  // interrupt
  output logic                                   irq_o
);
  import ccrcm_pkg::*;

  // rate table in MHz and divider in wait cycles before each read step
  localparam int RATE_MHZ [CCRCM_RATE_STEPS] = '{1, 3, 6, 7, 8, 10, 12,
    13, 17, 22, 25, 27, 33, 44, 50, 100};

  logic [15:0] rate_div [CCRCM_RATE_STEPS];
  genvar g;
  generate
    for (g = 0; g < CCRCM_RATE_STEPS; g++) begin : g_rate
      // wait cycles per step (step spacing is one more), rounded down, at least one
      assign rate_div[g] = 16'(CCRCM_CLK_MHZ / RATE_MHZ[g]);
    end
  endgenerate

  logic                    crc_enable_reg;
  logic                    halt_on_mismatch_reg;
  logic [3:0]              crc_check_rate_select_reg;
  logic [CCRCM_CRC_W-1:0]  ref_crc_reg;
  logic [CCRCM_CRC_W-1:0]  last_crc_reg;
  logic [CCRCM_IRQ_W-1:0]  irq_stat_reg;
  logic [CCRCM_IRQ_W-1:0]  irq_mask_reg;
  logic                    configured_reg;
  logic                    mismatch_reg;
  ccrcm_state_t            state_reg;
  logic [15:0]             div_cnt_reg;
  logic [CCRCM_IDX_W-1:0]  idx_reg;
  logic [CCRCM_CRC_W-1:0]  crc_reg;
  logic [CCRCM_CRC_W-1:0]  crc_next;
  logic                    pass_end;
  logic                    mis_evt;
  logic                    crc_mismatch_action_select;
  logic                    pin_sync1_reg;
  logic                    pin_sync2_reg;
  logic                    wr_ctrl;

  assign crc_mismatch_action_select = halt_on_mismatch_reg;
  assign wr_ctrl = reg_wr_i && (reg_addr_i == CCRCM_OFS_CTRL);

  // control registers written by software
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      crc_enable_reg            <= 1'b0;
      halt_on_mismatch_reg      <= 1'b0;
      crc_check_rate_select_reg <= CCRCM_RATE_DFLT;
      ref_crc_reg               <= '0;
      irq_mask_reg              <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == CCRCM_OFS_CTRL) begin
        crc_enable_reg            <= reg_wdata_i[CCRCM_CTRL_EN];
        halt_on_mismatch_reg      <= reg_wdata_i[CCRCM_CTRL_HALT];
        crc_check_rate_select_reg <= reg_wdata_i[CCRCM_CTRL_RATE +: 4];
      end else if (reg_addr_i == CCRCM_OFS_IRQ_MK) begin
        irq_mask_reg <= reg_wdata_i[CCRCM_IRQ_W-1:0];
      end else if (reg_addr_i == CCRCM_OFS_REF) begin
        ref_crc_reg <= reg_wdata_i;
      end
    end
  end

  // configuration phase tracking
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || config_start_i) begin
      configured_reg <= 1'b0;
    end else if (config_done_i) begin
      configured_reg <= 1'b1;
    end
  end

  // crc step over one readback word, msb first
  always_comb begin
    crc_next = crc_reg;
    for (int b = CCRCM_DATA_W - 1; b >= 0; b--) begin
      if (crc_next[CCRCM_CRC_W-1] ^ rb_data_i[b]) begin
        crc_next = {crc_next[CCRCM_CRC_W-2:0], 1'b0} ^ CCRCM_CRC_POLY;
      end else begin
        crc_next = {crc_next[CCRCM_CRC_W-2:0], 1'b0};
      end
    end
  end

  assign pass_end = (state_reg == CCRCM_READ) && (idx_reg == CCRCM_IDX_LAST);
  assign mis_evt  = pass_end && (crc_next != ref_crc_reg);

  // readback sequencer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !configured_reg || !crc_enable_reg) begin
      state_reg   <= CCRCM_IDLE;
      div_cnt_reg <= '0;
      idx_reg     <= '0;
      crc_reg     <= CCRCM_CRC_SEED;
    end else begin
      case (state_reg)
        CCRCM_IDLE: begin
          state_reg   <= CCRCM_WAIT;
          div_cnt_reg <= rate_div[crc_check_rate_select_reg];
        end
        CCRCM_WAIT: begin
          if (div_cnt_reg <= 16'h0001) begin
            state_reg <= CCRCM_READ;
          end else begin
            div_cnt_reg <= div_cnt_reg - 16'h0001;
          end
        end
        CCRCM_READ: begin
          crc_reg     <= crc_next;
          idx_reg     <= idx_reg + 4'h1;
          div_cnt_reg <= rate_div[crc_check_rate_select_reg];
          state_reg   <= CCRCM_WAIT;
          if (pass_end) begin
            crc_reg <= CCRCM_CRC_SEED;
            if (mis_evt && crc_mismatch_action_select) begin
              state_reg <= CCRCM_STOP;
            end
          end
        end
        default: begin
          state_reg <= CCRCM_STOP;
        end
      endcase
    end
  end

  // result and sticky mismatch, cleared only by reset or reconfiguration
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || config_start_i) begin
      mismatch_reg <= 1'b0;
      last_crc_reg <= '0;
    end else if (pass_end) begin
      last_crc_reg <= crc_next;
      if (mis_evt) begin
        mismatch_reg <= 1'b1;
      end
    end
  end

  // interrupt status, set wins over write-one-to-clear
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_stat_reg <= '0;
    end else begin
      for (int i = 0; i < CCRCM_IRQ_W; i++) begin
        if ((i == CCRCM_IRQ_MIS && mis_evt) ||
            (i == CCRCM_IRQ_DONE && pass_end)) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == CCRCM_OFS_IRQ_ST &&
                     reg_wdata_i[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // status pin sampling for readback in status
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_sync1_reg <= 1'b1;
      pin_sync2_reg <= 1'b1;
    end else begin
      pin_sync1_reg <= status_pin_i;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // open drain status pin: config role before done, crc role after
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      status_pin_o    <= 1'b0;
      status_pin_oe_o <= 1'b0;
    end else if (!configured_reg) begin
      status_pin_oe_o <= cfg_status_drive_low_i;
    end else begin
      status_pin_oe_o <= crc_enable_reg && mismatch_reg;
    end
  end

  assign rb_index_o = idx_reg;

  // register read, data one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      if (reg_addr_i == CCRCM_OFS_CTRL) begin
        reg_rdata_o <= {24'h00_0000, crc_check_rate_select_reg, 2'b00,
                        halt_on_mismatch_reg, crc_enable_reg};
      end else if (reg_addr_i == CCRCM_OFS_STAT) begin
        reg_rdata_o <= {26'h000_0000, state_reg, pin_sync2_reg,
                        configured_reg, mismatch_reg, state_reg == CCRCM_STOP};
      end else if (reg_addr_i == CCRCM_OFS_IRQ_ST) begin
        reg_rdata_o <= {30'h0000_0000, irq_stat_reg};
      end else if (reg_addr_i == CCRCM_OFS_IRQ_MK) begin
        reg_rdata_o <= {30'h0000_0000, irq_mask_reg};
      end else if (reg_addr_i == CCRCM_OFS_REF) begin
        reg_rdata_o <= ref_crc_reg;
      end else if (reg_addr_i == CCRCM_OFS_LAST) begin
        reg_rdata_o <= last_crc_reg;
      end else begin
        reg_rdata_o <= '0;
      end
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // checks
  property p_default_off;
    @(posedge ref_clk_i) $fell(reset_i) |-> !crc_enable_reg;
  endproperty
  a_default_off: assert property (p_default_off)
    else $error("checking not disabled after reset");

  property p_cfg_role;
    @(posedge ref_clk_i) disable iff (reset_i)
      !configured_reg |=> status_pin_oe_o == $past(cfg_status_drive_low_i);
  endproperty
  a_cfg_role: assert property (p_cfg_role)
    else $error("status pin left config role during configuration");

  property p_crc_role;
    @(posedge ref_clk_i) disable iff (reset_i)
      configured_reg && !crc_enable_reg && !config_start_i
      |=> !status_pin_oe_o;
  endproperty
  a_crc_role: assert property (p_crc_role)
    else $error("status pin driven with checking disabled");

  property p_mis_low;
    @(posedge ref_clk_i) disable iff (reset_i)
      mis_evt && crc_enable_reg && !config_start_i
      ##1 crc_enable_reg && !config_start_i
      |=> status_pin_oe_o && !status_pin_o;
  endproperty
  a_mis_low: assert property (p_mis_low)
    else $error("mismatch did not drive status pin low");

  property p_halt;
    @(posedge ref_clk_i) disable iff (reset_i)
      state_reg == CCRCM_STOP |=> $stable(idx_reg) && $stable(crc_reg);
  endproperty
  a_halt: assert property (p_halt)
    else $error("readback went on after halt");

  property p_continue;
    @(posedge ref_clk_i) disable iff (reset_i)
      mis_evt && !halt_on_mismatch_reg |=> state_reg == CCRCM_WAIT;
  endproperty
  a_continue: assert property (p_continue)
    else $error("checking stopped under continue action");

  property p_idle_off;
    @(posedge ref_clk_i) disable iff (reset_i)
      !crc_enable_reg |=> state_reg == CCRCM_IDLE;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("sequencer active while checking disabled");

  property p_rate;
    @(posedge ref_clk_i) disable iff (reset_i)
      state_reg == CCRCM_READ && !pass_end && crc_enable_reg
      && crc_check_rate_select_reg == 4'hf
      |=> state_reg == CCRCM_WAIT ##[1:3] state_reg != CCRCM_WAIT;
  endproperty
  a_rate: assert property (p_rate)
    else $error("fastest rate step too slow");

  property p_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
      mismatch_reg && !config_start_i |=> mismatch_reg;
  endproperty
  a_hold: assert property (p_hold)
    else $error("mismatch released without reconfiguration");

  c_pass: cover property (@(posedge ref_clk_i) pass_end && !mis_evt);
  c_mis:  cover property (@(posedge ref_clk_i) mis_evt);
  c_stop: cover property (@(posedge ref_clk_i) state_reg == CCRCM_STOP);
endmodule : ccrcm_top
`default_nettype wire

// File: verif/ccrcm_board_model.sv
// board side model: configuration memory words and pulled-up status pin
`timescale 1ns/100ps
`default_nettype none
module ccrcm_board_model
  import ccrcm_pkg::*;
(
  // readback side
  input  wire logic [ccrcm_pkg::CCRCM_IDX_W-1:0]  index_i,
  input  wire logic                               corrupt_i,
  output logic [ccrcm_pkg::CCRCM_DATA_W-1:0]      data_o,
  // status pin side
  input  wire logic                               pin_o_i,
  input  wire logic                               pin_oe_i,
  output logic                                    pin_level_o
);
  // word contents; an upset flips bit 0 of word 5
  assign data_o = {16'hc0de, 12'h000, index_i}
                ^ {31'h0, corrupt_i && (index_i == 4'h5)};
  // pull-up keeps the line high while nobody drives it
  assign pin_level_o = pin_oe_i ? pin_o_i : 1'b1;
endmodule : ccrcm_board_model
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the configuration memory crc monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import ccrcm_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        cfg_start = 1'b1;
  logic        cfg_done  = 1'b0;
  logic        drive_low = 1'b0;
  logic        corrupt   = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0000_0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [3:0]  rb_index;
  logic [31:0] rb_data;
  logic [31:0] rdata;
  logic        pin_in;
  logic        pin_o;
  logic        pin_oe;
  logic        irq;
  logic [31:0] rv;
  logic [3:0]  idx;
  int          num_errors  = 0;
  int          check_count = 0;
  int          cycles      = 0;
  int          n;
  int          mhz[16] = '{1, 3, 6, 7, 8, 10, 12, 13, 17, 22, 25, 27, 33,
                           44, 50, 100};
  // clock at 4 ns
  always #2 ref_clk_i = ~ref_clk_i;
  ccrcm_top dut_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .config_start_i(cfg_start),
    .config_done_i(cfg_done), .cfg_status_drive_low_i(drive_low),
    .rb_index_o(rb_index), .rb_data_i(rb_data), .status_pin_i(pin_in),
    .status_pin_o(pin_o), .status_pin_oe_o(pin_oe), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .irq_o(irq));
  ccrcm_board_model board_u (
    .index_i(rb_index), .corrupt_i(corrupt), .data_o(rb_data),
    .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_level_o(pin_in));
  // expected crc of one pass, optionally with the upset word
  function automatic logic [31:0] crc_pass(input logic upset);
    logic [31:0] c;
    logic [31:0] d;
    c = CCRCM_CRC_SEED;
    for (int i = 0; i < 16; i++) begin
      d = {16'hc0de, 12'h000, i[3:0]} ^ {31'h0, upset && (i == 5)};
      for (int b = 31; b >= 0; b--) begin
        c = {c[30:0], 1'b0} ^ ((c[31] ^ d[b]) ? CCRCM_CRC_POLY : 32'h0);
      end
    end
    return c;
  endfunction : crc_pass
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_i);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // poll the event status until the given bit is set
  task automatic wait_irq(input int b);
    for (int k = 0; k < 400; k++) begin
      rd_reg(CCRCM_OFS_IRQ_ST, rv);
      if (rv[b] === 1'b1) break;
    end
  endtask : wait_irq
  // one configuration cycle seen by the block
  task automatic reconfigure();
    @(posedge ref_clk_i);
    cfg_start <= 1'b1;
    @(posedge ref_clk_i);
    cfg_start <= 1'b0;
    cfg_done  <= 1'b1;
    @(posedge ref_clk_i);
    cfg_done  <= 1'b0;
  endtask : reconfigure
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // hang guard
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd_reg(CCRCM_OFS_CTRL, rv);
    `CHK(rv, 32'h0000_0000)
    // wrong reference while still configuring: pin keeps config role
    wr_reg(CCRCM_OFS_CTRL, 32'h0000_00f1);
    wr_reg(CCRCM_OFS_REF, 32'h0000_0000);
    drive_low <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    `CHK(pin_oe, 1'b1)
    drive_low <= 1'b0;
    repeat (100) @(posedge ref_clk_i);
    `CHK(pin_oe, 1'b0)
    $display("test config role done");
    reconfigure();
    wr_reg(CCRCM_OFS_REF, crc_pass(1'b0));
    wr_reg(CCRCM_OFS_IRQ_MK, 32'h0000_0003);
    wr_reg(CCRCM_OFS_IRQ_ST, 32'h0000_0003);
    wait_irq(CCRCM_IRQ_DONE);
    `CHK(irq, 1'b1)
    rd_reg(CCRCM_OFS_LAST, rv);
    `CHK(rv, crc_pass(1'b0))
    `CHK(pin_oe, 1'b0)
    wr_reg(CCRCM_OFS_IRQ_MK, 32'h0000_0001);
    wr_reg(CCRCM_OFS_IRQ_ST, 32'h0000_0003);
    `CHK(irq, 1'b0)
    $display("test clean pass done");
    corrupt <= 1'b1;
    wait_irq(CCRCM_IRQ_MIS);
    repeat (3) @(posedge ref_clk_i);
    `CHK({pin_oe, pin_in, irq}, 3'b101)
    wr_reg(CCRCM_OFS_IRQ_ST, 32'h0000_0003);
    wait_irq(CCRCM_IRQ_MIS);
    `CHK(rv[0], 1'b1)
    corrupt <= 1'b0;
    repeat (200) @(posedge ref_clk_i);
    `CHK(pin_oe, 1'b1)
    $display("test continue done");
    reconfigure();
    repeat (4) @(posedge ref_clk_i);
    `CHK(pin_oe, 1'b0)
    wr_reg(CCRCM_OFS_CTRL, 32'h0000_00f3);
    corrupt <= 1'b1;
    wr_reg(CCRCM_OFS_IRQ_ST, 32'h0000_0003);
    wait_irq(CCRCM_IRQ_MIS);
    rd_reg(CCRCM_OFS_LAST, rv);
    `CHK(rv, crc_pass(1'b1))
    rd_reg(CCRCM_OFS_STAT, rv);
    `CHK(rv[1:0], 2'b11)
    wr_reg(CCRCM_OFS_IRQ_ST, 32'h0000_0003);
    repeat (200) @(posedge ref_clk_i);
    rd_reg(CCRCM_OFS_IRQ_ST, rv);
    `CHK(rv, 32'h0000_0000)
    $display("test halt done");
    wr_reg(CCRCM_OFS_CTRL, 32'h0000_0002);
    wr_reg(CCRCM_OFS_IRQ_ST, 32'h0000_0003);
    repeat (200) @(posedge ref_clk_i);
    rd_reg(CCRCM_OFS_IRQ_ST, rv);
    `CHK({rv, rb_index, pin_oe}, 37'h0)
    rd_reg(8'h40, rv);
    `CHK(rv, 32'h0000_0000)
    $display("test disabled done");
    // every rate step: spacing of readback steps inside a pass
    for (int r = 0; r < 16; r++) begin
      wr_reg(CCRCM_OFS_CTRL, 32'h0000_0001 | (r << 4));
      do begin
        idx = rb_index;
        while (rb_index === idx) @(negedge ref_clk_i);
      end while (rb_index inside {4'h0, 4'h1, 4'hf});
      idx = rb_index;
      n = 0;
      while (rb_index === idx && n < 400) begin
        @(negedge ref_clk_i);
        n++;
      end
      `CHK(n, 250 / mhz[r] + 1)
    end
    $display("test rates done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
